//--- rtl/gdc_top.sv
// Gate driver protection configuration register and the protection logic it steers.
// Summary of operation
// [RQ1] The configuration register sits at offset ACh and resets to 10228100h.
// [RQ2] The slew rate field picks 25, 50, 125 or 200 V/us for codes 0 to 3.
// [RQ3] Writing one to bit 23 clears every latched fault and the bit reads back as zero.
// [RQ4] The overvoltage threshold bit selects a 32 V trip level at zero and 20 V at one.
// [RQ5] Bit 18 enables overvoltage protection when one and disables it when zero.
// [RQ6] Bit 16 lets an over-temperature warning pull the fault pin low when one.
// [RQ7] The filter field demands 0.2, 0.6, 1.2 or 1.6 us of steady overcurrent before acceptance.
// [RQ8] The retry bit makes the driver wait 5 ms at zero and 500 ms at one before retrying.
// [RQ9] The overcurrent threshold bit selects a typical 9 A trip at zero and 13 A at one.
// [RQ10] Response code 0 latches an overcurrent fault and code 1 retries it automatically.
// [RQ11] Response code 2 reports without acting and code 3 neither reports nor acts.
// [RQ12] The gain field selects 0.24, 0.48, 0.96 or 1.92 V/A for codes 0 to 3.
// [RQ13] The gain field applies only while automatic gain selection is off.
// [RQ14] Software keeps reserved fields at their reset values by read-modify-write.
// [RQ15] Bit 31 holds a parity bit that resets to zero and is stored as written.
`timescale 1ns/1ps
`include "gdc_map.svh"
module gdc_top #(
  parameter int RETRY_SHORT_CYC = `GDC_MS2CYC(`GDC_RETRY_SHORT_MS),
  parameter int RETRY_LONG_CYC = `GDC_MS2CYC(`GDC_RETRY_LONG_MS),
  parameter int RETRY_W = 27
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [`GDC_ADDR_W-1:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic overcurrent_in,
  input wire logic overtemp_warn_in,
  input wire logic supply_above_32v_in,
  input wire logic supply_above_20v_in,
  input wire logic auto_sense_gain_enable,
  input wire logic [1:0] auto_sense_gain_code,
  output logic [1:0] slew_rate_code,
  output logic overcurrent_threshold,
  output logic [1:0] sense_amp_gain,
  output logic drive_disable,
  output logic overcurrent_fault,
  output logic overvoltage_fault,
  output logic fault_indicator_pin_n
);

  // ************************************************************
  // Elaboration checks
  // ************************************************************
  localparam int FILT_W = 9;
  localparam logic [FILT_W-1:0] FILT0_CYC = FILT_W'(`GDC_NS2CYC(`GDC_FILT0_NS));
  localparam logic [FILT_W-1:0] FILT1_CYC = FILT_W'(`GDC_NS2CYC(`GDC_FILT1_NS));
  localparam logic [FILT_W-1:0] FILT2_CYC = FILT_W'(`GDC_NS2CYC(`GDC_FILT2_NS));
  localparam logic [FILT_W-1:0] FILT3_CYC = FILT_W'(`GDC_NS2CYC(`GDC_FILT3_NS));

  generate
    if (RETRY_W > 31 || RETRY_SHORT_CYC < 1 || RETRY_LONG_CYC < 1 ||
        RETRY_SHORT_CYC >= (1 << RETRY_W) || RETRY_LONG_CYC >= (1 << RETRY_W)) begin : g_bad_retry
      $error("gdc_top: retry counts do not fit the retry counter");
    end
    // A faster clock would silently wrap the longest filter count, so refuse it here.
    if (`GDC_NS2CYC(`GDC_FILT3_NS) >= (1 << FILT_W)) begin : g_bad_filter
      $error("gdc_top: filter count does not fit the filter counter");
    end
  endgenerate

  // ************************************************************
  // Helpers
  // ************************************************************
  function automatic logic [FILT_W-1:0] filt_cycles(input logic [1:0] code);
    case (code)
      2'h0: filt_cycles = FILT0_CYC;
      2'h1: filt_cycles = FILT1_CYC;
      2'h2: filt_cycles = FILT2_CYC;
      default: filt_cycles = FILT3_CYC;
    endcase
  endfunction : filt_cycles

  function automatic logic [RETRY_W-1:0] retry_cycles(input logic long_sel);
    retry_cycles = long_sel ? RETRY_W'(RETRY_LONG_CYC - 1) : RETRY_W'(RETRY_SHORT_CYC - 1);
  endfunction : retry_cycles

  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  logic [3:0] pin_meta_r;
  logic [3:0] pin_sync_r;
  logic oc_pin;
  logic otw_pin;
  logic above32_pin;
  logic above20_pin;

  // Comparator and sense outputs come from the analogue domain and must settle first.
  always_ff @(posedge mclk) begin
    if (rst) begin
      pin_meta_r <= 4'h0;
      pin_sync_r <= 4'h0;
    end else begin
      pin_meta_r <= {supply_above_20v_in, supply_above_32v_in, overtemp_warn_in, overcurrent_in};
      pin_sync_r <= pin_meta_r;
    end
  end

  assign oc_pin = pin_sync_r[0];
  assign otw_pin = pin_sync_r[1];
  assign above32_pin = pin_sync_r[2];
  assign above20_pin = pin_sync_r[3];

  // ************************************************************
  // Configuration register
  // ************************************************************
  logic [31:0] cfg_r;
  logic cfg_hit;
  logic clear_pulse;
  logic [31:0] cfg_wval;

  assign cfg_hit = (reg_addr == `GDC_CFG_OFFSET); // [RQ1]
  assign clear_pulse = reg_wr && cfg_hit && reg_wdata[`GDC_CLR_BIT]; // [RQ3]

  // Reserved bits are stored as written, so software must write back what it read.
  always_comb begin
    cfg_wval = reg_wdata;
    cfg_wval[`GDC_CLR_BIT] = 1'b0; // [RQ3]
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      cfg_r <= `GDC_CFG_RESET; // [RQ1] [RQ15]
    end else if (reg_wr && cfg_hit) begin
      cfg_r <= cfg_wval; // [RQ14] [RQ15]
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      reg_rdata <= 32'h00000000;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      reg_rdata <= (reg_rd && cfg_hit) ? cfg_r : 32'h00000000;
    end
  end

  // ************************************************************
  // Field decode
  // ************************************************************
  logic ov_sel;
  logic ov_en;
  logic overtemp_warning_report;
  logic [1:0] filt_code;
  logic retry_long;
  gdc_pkg::gdc_oc_mode_t oc_mode;

  assign ov_sel = cfg_r[`GDC_OVSEL_BIT];
  assign ov_en = cfg_r[`GDC_OVEN_BIT];
  assign overtemp_warning_report = cfg_r[`GDC_OTWREP_BIT];
  assign filt_code = cfg_r[`GDC_FILT_LSB +: 2];
  assign retry_long = cfg_r[`GDC_RETRY_BIT];
  assign oc_mode = gdc_pkg::gdc_oc_mode_t'(cfg_r[`GDC_OCMODE_LSB +: 2]);

  // The analogue drivers take the codes directly; the encodings are fixed by the drive stage.
  always_ff @(posedge mclk) begin
    if (rst) begin
      slew_rate_code <= 2'h0;
      overcurrent_threshold <= 1'b0;
      sense_amp_gain <= 2'h0;
    end else begin
      slew_rate_code <= cfg_r[`GDC_SLEW_LSB +: 2]; // [RQ2]
      overcurrent_threshold <= cfg_r[`GDC_OCLVL_BIT]; // [RQ9]
      sense_amp_gain <= auto_sense_gain_enable ? auto_sense_gain_code : cfg_r[`GDC_GAIN_LSB +: 2]; // [RQ12] [RQ13]
    end
  end

  // ************************************************************
  // Overcurrent filter
  // ************************************************************
  logic oc_accepted;
  logic oc_accepted_d_r;
  logic oc_event;

  gdc_glitch_filter #(
    .CW(FILT_W)
  ) u_filter (
    .mclk(mclk),
    .rst(rst),
    .level_in(oc_pin),
    .limit(filt_cycles(filt_code)), // [RQ7]
    .accepted(oc_accepted)
  );

  always_ff @(posedge mclk) begin
    if (rst) begin
      oc_accepted_d_r <= 1'b0;
    end else begin
      oc_accepted_d_r <= oc_accepted;
    end
  end

  assign oc_event = oc_accepted && !oc_accepted_d_r;

  // ************************************************************
  // Overcurrent response
  // ************************************************************
  gdc_pkg::gdc_state_t state_r;
  gdc_pkg::gdc_state_t state_nxt;
  logic [RETRY_W-1:0] retry_cnt_r;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      gdc_pkg::GDC_ST_RUN: begin
        if (oc_event && oc_mode == gdc_pkg::GDC_OC_LATCH) begin
          state_nxt = gdc_pkg::GDC_ST_LATCH; // [RQ10]
        end else if (oc_event && oc_mode == gdc_pkg::GDC_OC_RETRY) begin
          state_nxt = gdc_pkg::GDC_ST_WAIT; // [RQ10]
        end
      end
      gdc_pkg::GDC_ST_WAIT: begin
        if (retry_cnt_r == '0) begin
          state_nxt = gdc_pkg::GDC_ST_RUN; // [RQ8]
        end
      end
      gdc_pkg::GDC_ST_LATCH: begin
        // A new overcurrent in the clear cycle keeps the latch.
        if (clear_pulse && !oc_event) begin
          state_nxt = gdc_pkg::GDC_ST_RUN; // [RQ3]
        end
      end
      default: begin
        state_nxt = gdc_pkg::GDC_ST_RUN;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      state_r <= gdc_pkg::GDC_ST_RUN;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      retry_cnt_r <= '0;
    end else if (state_r == gdc_pkg::GDC_ST_RUN && state_nxt == gdc_pkg::GDC_ST_WAIT) begin
      retry_cnt_r <= retry_cycles(retry_long); // [RQ8]
    end else if (retry_cnt_r != '0) begin
      retry_cnt_r <= retry_cnt_r - {{(RETRY_W-1){1'b0}}, 1'b1};
    end
  end

  // ************************************************************
  // Fault flags
  // ************************************************************
  logic oc_report;
  logic ov_trip;

  assign oc_report = oc_event && (oc_mode != gdc_pkg::GDC_OC_IGNORE); // [RQ11]
  assign ov_trip = ov_en && (ov_sel ? above20_pin : above32_pin); // [RQ4] [RQ5]

  // The set term wins, so an event arriving with the clear is never lost.
  always_ff @(posedge mclk) begin
    if (rst) begin
      overcurrent_fault <= 1'b0;
    end else if (oc_report) begin
      overcurrent_fault <= 1'b1; // [RQ11]
    end else if (clear_pulse) begin
      overcurrent_fault <= 1'b0; // [RQ3]
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      overvoltage_fault <= 1'b0;
    end else if (ov_trip) begin
      overvoltage_fault <= 1'b1; // [RQ5]
    end else if (clear_pulse) begin
      overvoltage_fault <= 1'b0; // [RQ3]
    end
  end

  // ************************************************************
  // Driver shutdown and fault pin
  // ************************************************************
  // Overvoltage disables the bridge only while the supply is high; the flag stays for software.
  always_ff @(posedge mclk) begin
    if (rst) begin
      drive_disable <= 1'b0;
    end else begin
      drive_disable <= (state_nxt != gdc_pkg::GDC_ST_RUN) || ov_trip; // [RQ10] [RQ5]
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      fault_indicator_pin_n <= 1'b1;
    end else begin
      fault_indicator_pin_n <= !(overcurrent_fault || overvoltage_fault || (overtemp_warning_report && otw_pin)); // [RQ6]
    end
  end

endmodule : gdc_top

//--- rtl/gdc_map.svh
// Register offsets, field positions, reset values and timing counts of the gate driver configuration block.
`ifndef GDC_MAP_SVH
`define GDC_MAP_SVH

// ************************************************************
// Register map
// ************************************************************
`define GDC_ADDR_W 16
`define GDC_CFG_OFFSET 16'h00ac
`define GDC_CFG_RESET 32'h10228100

// ************************************************************
// Field positions
// ************************************************************
`define GDC_PARITY_BIT 31
`define GDC_SLEW_LSB 26
`define GDC_CLR_BIT 23
`define GDC_OVSEL_BIT 19
`define GDC_OVEN_BIT 18
`define GDC_OTWREP_BIT 16
`define GDC_FILT_LSB 12
`define GDC_RETRY_BIT 11
`define GDC_OCLVL_BIT 10
`define GDC_OCMODE_LSB 8
`define GDC_GAIN_LSB 0

// ************************************************************
// Timing
// ************************************************************
`define GDC_CLK_MHZ 200
`define GDC_FILT0_NS 200
`define GDC_FILT1_NS 600
`define GDC_FILT2_NS 1200
`define GDC_FILT3_NS 1600
`define GDC_NS2CYC(ns) ((((ns) * `GDC_CLK_MHZ) + 999) / 1000)
`define GDC_RETRY_SHORT_MS 5
`define GDC_RETRY_LONG_MS 500
`define GDC_MS2CYC(ms) ((ms) * `GDC_CLK_MHZ * 1000)

`endif

//--- rtl/gdc_pkg.sv
// Types shared by the gate driver configuration block.
package gdc_pkg;

  // ************************************************************
  // Overcurrent response codes
  // ************************************************************
  typedef enum logic [1:0] {
    GDC_OC_LATCH = 2'h0,
    GDC_OC_RETRY = 2'h1,
    GDC_OC_REPORT = 2'h2,
    GDC_OC_IGNORE = 2'h3
  } gdc_oc_mode_t;

  // ************************************************************
  // Overcurrent protection states
  // ************************************************************
  typedef enum logic [1:0] {
    GDC_ST_RUN = 2'h0,
    GDC_ST_WAIT = 2'h1,
    GDC_ST_LATCH = 2'h2
  } gdc_state_t;

endpackage : gdc_pkg

//--- rtl/gdc_glitch_filter.sv
// Glitch filter that accepts a level only after it has stood for a programmable number of cycles.
`timescale 1ns/1ps
module gdc_glitch_filter #(
  parameter int CW = 9
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic level_in,
  input wire logic [CW-1:0] limit,
  output logic accepted
);

  logic [CW-1:0] count_r;

  generate
    if (CW < 2) begin : g_bad_width
      $error("gdc_glitch_filter: counter width too small");
    end
  endgenerate

  // ************************************************************
  // Qualification counter
  // ************************************************************
  // A glitch shorter than the limit restarts the count, so only a steady level passes.
  always_ff @(posedge mclk) begin
    if (rst || !level_in) begin
      count_r <= '0;
    end else if (count_r != limit) begin
      count_r <= count_r + {{(CW-1){1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      accepted <= 1'b0;
    end else begin
      accepted <= level_in && (count_r == limit);
    end
  end

endmodule : gdc_glitch_filter

//--- verification/gdc_top_props.sv
// Concurrent checks on the ports of the gate driver configuration block.
`timescale 1ns/1ps
`include "gdc_map.svh"
module gdc_top_props (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [`GDC_ADDR_W-1:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_wdata,
  input wire logic [31:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic overcurrent_in,
  input wire logic auto_sense_gain_enable,
  input wire logic [1:0] auto_sense_gain_code,
  input wire logic [1:0] slew_rate_code,
  input wire logic overcurrent_threshold,
  input wire logic [1:0] sense_amp_gain,
  input wire logic drive_disable,
  input wire logic overcurrent_fault,
  input wire logic overvoltage_fault,
  input wire logic fault_indicator_pin_n
);
  // ********
  // Properties
  // ********
  logic [31:0] wd1_r;
  logic [31:0] wd2_r;

  // Two cycles of write data history, because the derived outputs lag a write by two edges.
  always_ff @(posedge mclk) begin
    wd1_r <= reg_wdata;
    wd2_r <= wd1_r;
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (rst);

  sequence cfg_wr_s;
    reg_wr && reg_addr == `GDC_CFG_OFFSET;
  endsequence

  rd_answer_a: assert property (reg_rd |=> reg_rvalid)
    else $error("read not answered");
  unmapped_zero_a: assert property (reg_rd && reg_addr != `GDC_CFG_OFFSET |=> reg_rdata == 32'h0)
    else $error("unmapped read not zero");
  clear_selfclr_a: assert property (reg_rvalid |-> !reg_rdata[`GDC_CLR_BIT])
    else $error("clear bit read back as one");
  slew_follow_a: assert property (cfg_wr_s |=> ##1 slew_rate_code == wd2_r[27:26])
    else $error("slew code not applied");
  thresh_follow_a: assert property (cfg_wr_s |=> ##1 overcurrent_threshold == wd2_r[10])
    else $error("threshold not applied");
  auto_gain_a: assert property (auto_sense_gain_enable |=> sense_amp_gain == $past(auto_sense_gain_code))
    else $error("auto gain not used");
  fault_pin_a: assert property (overcurrent_fault || overvoltage_fault |=> !fault_indicator_pin_n)
    else $error("fault not shown on pin");
  oc_filtered_a: assert property ($rose(overcurrent_fault) |-> $past(overcurrent_in, 4) && $past(overcurrent_in, 30))
    else $error("overcurrent accepted too soon");
  drive_cause_a: assert property ($rose(drive_disable) |-> ##[0:2] (overcurrent_fault || overvoltage_fault))
    else $error("bridge off without fault");
endmodule : gdc_top_props

bind gdc_top gdc_top_props u_gdc_top_props (.mclk, .rst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
  .reg_rvalid, .overcurrent_in, .auto_sense_gain_enable, .auto_sense_gain_code, .slew_rate_code,
  .overcurrent_threshold, .sense_amp_gain, .drive_disable, .overcurrent_fault, .overvoltage_fault,
  .fault_indicator_pin_n);

//--- verification/gdc_top_bench.sv
// Self-checking bench for the gate driver configuration block.
`timescale 1ns/1ps
`include "gdc_map.svh"
module gdc_top_bench;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [15:0] reg_addr = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_wdata = 32'h0;
  logic oc = 1'b0;
  logic otw = 1'b0;
  logic a32 = 1'b0;
  logic a20 = 1'b0;
  logic age = 1'b0;
  logic [1:0] agc = 2'h0;
  logic [31:0] reg_rdata, cfg, q, d;
  logic [1:0] slew, gain, m;
  logic reg_rvalid, thr, drv, ocf, ovf, pin_n, e;
  int n_mismatch = 0;
  int n_checks = 0;
  int nf [4] = '{40, 120, 240, 320};

  always #2.5 mclk = ~mclk;

  gdc_top #(.RETRY_SHORT_CYC(20), .RETRY_LONG_CYC(50)) u_gdc_top (
    .mclk, .rst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .reg_rvalid,
    .overcurrent_in(oc), .overtemp_warn_in(otw), .supply_above_32v_in(a32), .supply_above_20v_in(a20),
    .auto_sense_gain_enable(age), .auto_sense_gain_code(agc), .slew_rate_code(slew),
    .overcurrent_threshold(thr), .sense_amp_gain(gain), .drive_disable(drv), .overcurrent_fault(ocf),
    .overvoltage_fault(ovf), .fault_indicator_pin_n(pin_n));

  // ********
  // Tasks
  // ********
  task chk(input logic ok, input string s);
    n_checks++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("ERROR %0t %s", $time, s);
    end
  endtask : chk

  task cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : cyc

  task wr(input logic [15:0] a, input logic [31:0] v);
    reg_addr = a;
    reg_wdata = v;
    reg_wr = 1'b1;
    cyc(1);
    reg_wr = 1'b0;
    if (a == `GDC_CFG_OFFSET) cfg = v & 32'hff7fffff;
  endtask : wr

  task rd(input logic [15:0] a);
    // A free cycle first, so two reads in a row never lower and raise the strobe in one step.
    cyc(1);
    reg_addr = a;
    reg_rd = 1'b1;
    cyc(1);
    reg_rd = 1'b0;
    chk(reg_rvalid === 1'b1, "no read answer");
    q = reg_rdata;
  endtask : rd

  // Keeps the reserved bits at their reset values and always issues a fault clear.
  function logic [31:0] mk(logic [1:0] md, logic [1:0] f, logic rt, logic os, logic oe, logic ot);
    return 32'h10a28000 | {12'h0, os, oe, 1'b0, ot, 2'h0, f, rt, 1'b0, md, 8'h0};
  endfunction : mk

  task final_report;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : final_report

  // ********
  // Tests
  // ********
  initial begin
    #100000;
    n_mismatch++;
    final_report();
  end

  initial begin
    d = $urandom(32'hc3528d44);
    cfg = 32'h10228100;
    cyc(10);
    rst = 1'b0;
    rd(`GDC_CFG_OFFSET);
    chk(q === 32'h10228100, "reset value");
    chk({slew, thr, gain, pin_n} === 6'h01, "reset outputs");
    wr(16'h00ae, $urandom);
    rd(16'h00ae);
    chk(q === 32'h0, "unmapped read");
    rd(`GDC_CFG_OFFSET);
    chk(q === cfg, "unmapped write landed");
    for (int i = 0; i < 12; i++) begin
      d = (i < 4) ? {16{i[1:0]}} : $urandom;
      age = (i > 7);
      agc = 2'($urandom);
      wr(`GDC_CFG_OFFSET, d);
      cyc(1);
      chk(slew === d[27:26], "slew code");
      chk(thr === d[10], "threshold");
      chk(gain === (age ? agc : d[1:0]), "gain");
      rd(`GDC_CFG_OFFSET);
      chk(q === cfg, "readback");
    end
    for (int t = 0; t < 5; t++) begin
      m = (t == 4) ? 2'h1 : 2'(t);
      wr(`GDC_CFG_OFFSET, mk(m, 2'h0, t == 4, 1'b0, 1'b0, 1'b0));
      cyc(2);
      chk({drv, ocf, ovf, pin_n} === 4'h1, "clear");
      oc = 1'b1;
      cyc(52);
      chk({drv, ocf, pin_n} === {m < 2'h2, m != 2'h3, m == 2'h3}, "oc response");
      oc = 1'b0;
      cyc(20);
      chk(drv === (m == 2'h0 || t == 4), "retry wait");
      cyc(40);
      chk(drv === (m == 2'h0), "retry end");
    end
    for (int f = 0; f < 4; f++) begin
      wr(`GDC_CFG_OFFSET, mk(2'h2, 2'(f), 1'b0, 1'b0, 1'b0, 1'b0));
      oc = 1'b1;
      cyc(nf[f] - 4);
      oc = 1'b0;
      cyc(6);
      chk(ocf === 1'b0, "short pulse");
      oc = 1'b1;
      cyc(nf[f] + 6);
      oc = 1'b0;
      cyc(2);
      chk({ocf, drv} === 2'h2, "long pulse");
    end
    for (int i = 0; i < 16; i++) begin
      // Levels drop before each clear so the synchroniser cannot relatch a stale level.
      wr(`GDC_CFG_OFFSET, mk(2'h3, 2'h0, 1'b0, i[3], i[2], 1'b0));
      {a32, a20} = 2'(i);
      cyc(6);
      e = i[2] && (i[3] ? a20 : a32);
      chk({ovf, drv} === {e, e}, "overvoltage");
      {a32, a20} = 2'h0;
      cyc(5);
      chk(drv === 1'b0, "ov release");
    end
    // Mid-run reset with the overvoltage flag still set must bring everything back.
    rst = 1'b1;
    cyc(3);
    rst = 1'b0;
    cfg = `GDC_CFG_RESET;
    chk({ovf, drv, pin_n} === 3'h1, "flags after reset");
    rd(`GDC_CFG_OFFSET);
    chk(q === `GDC_CFG_RESET, "reset value again");
    for (int r = 0; r < 2; r++) begin
      wr(`GDC_CFG_OFFSET, mk(2'h3, 2'h0, 1'b0, 1'b0, 1'b0, r[0]));
      otw = 1'b1;
      cyc(5);
      chk(pin_n === !r[0], "warning report");
      otw = 1'b0;
      cyc(4);
      chk(pin_n === 1'b1, "warning gone");
    end
    final_report();
  end
endmodule : gdc_top_bench
